// >>> logic/field_match.v
`timescale 1ns/100ps
`default_nettype none
`include "macsec_map.vh"
module field_match (
   input wire [15:0] etype, // resolved frame ethertype
   input wire [1:0] flags, // {control frame, sectag seen}
   input wire [31:0] rule, // programmed rule word
   output wire hit // rule matches this frame
);
   // flag compare only when the rule asks for it
   assign hit = rule[`RF_EN] && (etype == rule[`RF_ET]) &&
                (!rule[`RF_USEF] || (flags == rule[`RF_FLAGS]));
endmodule
`default_nettype wire

// >>> logic/macsec_frame_pipeline.v
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "macsec_map.vh"
module macsec_frame_pipeline (
   input wire pclk, // clock
   input wire presetn, // async reset, active low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output wire [31:0] prdata, // apb read data
   output wire pready, // apb ready
   output wire pslverr, // apb error on unmapped address
   input wire in_valid, // switch side word valid
   output wire in_ready, // switch side ready
   input wire [31:0] in_data, // switch side data
   input wire in_sop, // first word of frame
   input wire in_eop, // last word of frame
   output wire out_valid, // mac side word valid
   input wire out_ready, // mac side ready
   output wire [31:0] out_data, // mac side data
   output wire out_sop, // first word of frame
   output wire out_eop, // last word of frame
   output wire out_drop // with eop: discard this frame
);
   localparam S_HEAD = 6'b000001;
   localparam S_DEC = 6'b000010;
   localparam S_EMIT = 6'b000100;
   localparam S_PASS = 6'b001000;
   localparam S_ICV = 6'b010000;
   localparam S_DISC = 6'b100000;

   reg [5:0] state_r;
   reg [31:0] hb_r [0:4];
   reg [2:0] hcnt_r, ei_r, pcp_r, cls_r, uidx_r;
   reg eop_seen_r, enc_r, ver_r, vlan_r, rmw_r, ap_wait_r;
   reg [1:0] act_r, ctrl_r;
   reg [7:0] defact_r, skip_r, pend_r;
   reg [15:0] mtu_r, len_r, wcnt_r;
   reg [15:0] mtupri_r [0:7];
   reg [31:0] crule_r [0:20];
   reg [31:0] flow_r [0:3];
   reg [31:0] chk_r [0:7];
   reg [31:0] key_r, pn_r, icv_r, rd_r;
   reg [3:0] clr_r;
   reg out_valid_r, out_sop_r, out_eop_r, out_drop_r;
   reg [31:0] out_data_r;
   integer i, j, q;

   // header fields; vlan pushes the real type one word down
   wire [15:0] et0 = hb_r[3][31:16];
   wire vlan = (et0 == `ET_VLAN);
   wire [15:0] et = vlan ? hb_r[4][31:16] : et0;
   wire [7:0] tci = vlan ? hb_r[4][15:8] : hb_r[3][15:8];
   wire sectag = (et == `ET_SECTAG);
   wire sec_ok = sectag && !tci[`TCI_VER];
   wire [20:0] crule_hit;
   wire [3:0] flow_hit;
   wire [7:0] chk_hit;
   wire ctrl_frm = |crule_hit;
   wire [2:0] cls = {ctrl_frm, sectag, sec_ok};

   genvar g;
   // control frame rules see only the type
   generate
      for (g = 0; g < `N_CRULE; g = g + 1) begin : cr
         field_match u_m (.etype(et), .flags(2'h0), .rule(crule_r[g]), .hit(crule_hit[g]));
      end
      for (g = 0; g < `N_FLOW; g = g + 1) begin : fl
         field_match u_m (.etype(et), .flags({ctrl_frm, sectag}), .rule(flow_r[g]),
            .hit(flow_hit[g]));
      end
      for (g = 0; g < `N_CHK; g = g + 1) begin : ck
         field_match u_m (.etype(et), .flags({ctrl_frm, sectag}), .rule(chk_r[g]),
            .hit(chk_hit[g]));
      end
   endgenerate

   // priority resolution; equal priority keeps the lower index
   reg fl_any, ck_any;
   reg [2:0] fl_pri, ck_pri;
   reg [1:0] fl_act, ck_act;
   always @* begin
      fl_any = 1'b0;
      fl_pri = 3'h0;
      fl_act = `ACT_DROP;
      ck_any = 1'b0;
      ck_pri = 3'h0;
      ck_act = `ACT_DROP;
      for (i = 0; i < `N_FLOW; i = i + 1) begin
         if (flow_hit[i] && (!fl_any || flow_r[i][`RF_PRIO] > fl_pri)) begin
            fl_any = 1'b1;
            fl_pri = flow_r[i][`RF_PRIO];
            fl_act = flow_r[i][`RF_ACT];
         end
      end
      for (i = 0; i < `N_CHK; i = i + 1) begin
         if (chk_hit[i] && (!ck_any || chk_r[i][`RF_PRIO] > ck_pri)) begin
            ck_any = 1'b1;
            ck_pri = chk_r[i][`RF_PRIO];
            ck_act = chk_r[i][`RF_ACT];
         end
      end
   end

   // early decision, all from the held header
   wire en = ctrl_r[`C_EN];
   wire egress = ctrl_r[`C_EGR];
   wire [1:0] def_act = defact_r[cls] ? `ACT_BYPASS : `ACT_DROP;
   wire [1:0] dec_act = !en ? `ACT_BYPASS : (fl_any ? fl_act : def_act);
   wire chk_drop = en && ck_any && (ck_act == `ACT_DROP);
   wire viol = (dec_act == `ACT_MACSEC) && (egress ? sectag : !sec_ok);
   wire runt = (hcnt_r != `HDR_WORDS);
   wire early_drop = runt || (dec_act == `ACT_DROP) || chk_drop || viol;

   // counter bookkeeping
   wire clr_done = clr_r[3];
   wire stat_free = clr_done && (pend_r == 8'h00);
   wire [31:0] ram_rd;
   wire acc = psel && penable;
   wire st_acc = acc && (paddr >= `A_STAT) && (paddr < `A_STAT_E);
   wire grant = st_acc && clr_done && !rmw_r && !ap_wait_r;
   wire ustart = clr_done && !rmw_r && (pend_r != 8'h00) && !st_acc;

   function [2:0] low_bit;
      input [7:0] m;
      integer k;
      begin
         low_bit = 3'h0;
         for (k = 7; k >= 0; k = k - 1) begin
            if (m[k]) begin
               low_bit = k[2:0];
            end
         end
      end
   endfunction

   // counters touched by a frame that reached the output
   function [7:0] fin_mask;
      input over, bad, enc, ver, byp;
      begin
         fin_mask = 8'h00;
         if (over) begin
            fin_mask[`ST_DMTU] = 1'b1;
         end else if (bad) begin
            fin_mask[`ST_DCOMP] = 1'b1;
         end else begin
            fin_mask[`ST_PASS] = 1'b1;
         end
         fin_mask[`ST_PROT] = enc;
         fin_mask[`ST_VALID] = ver && !bad;
         fin_mask[`ST_BYP] = byp;
      end
   endfunction

   // keystream word: key mixed with packet number and word count
   wire [31:0] ks = key_r ^ {pn_r[15:0], wcnt_r};
   wire [2:0] last_ei = enc_r ? `LAST_ENC : `LAST_PLAIN;
   wire [2:0] hsel = ei_r - 3'h2;

   // word the engine is offering this cycle
   reg prod, psop, peop, penc;
   reg [31:0] pdata;
   always @* begin
      prod = 1'b0;
      psop = 1'b0;
      peop = 1'b0;
      penc = 1'b0;
      pdata = in_data;
      case (state_r)
         S_EMIT: begin
            psop = (ei_r == 3'h0);
            peop = (ei_r == last_ei) && eop_seen_r && !enc_r;
            prod = !peop || stat_free;
            if (!enc_r || ei_r < 3'h3) begin
               pdata = hb_r[ei_r];
            end else if (ei_r == 3'h3) begin
               pdata = {`ET_SECTAG, `TCI_EGR, 8'h00};
            end else if (ei_r == 3'h4) begin
               pdata = pn_r;
            end else begin
               pdata = hb_r[hsel] ^ ks;
               penc = 1'b1;
            end
         end
         S_PASS: begin
            prod = in_valid && stat_free;
            peop = in_eop && !enc_r;
            penc = enc_r;
            pdata = enc_r ? (in_data ^ ks) : in_data;
         end
         S_ICV: begin
            prod = stat_free;
            peop = 1'b1;
            pdata = icv_r;
         end
         default: begin
            prod = 1'b0;
         end
      endcase
   end

   wire can = !out_valid_r || out_ready;
   wire fire = prod && can;
   assign in_ready = (state_r == S_HEAD) || (state_r == S_DISC) ||
                     ((state_r == S_PASS) && can && stat_free);
   wire accept = in_valid && in_ready;
   wire [15:0] len_nxt = len_r + `WORD_BYTES;
   wire over = (len_nxt > mtu_r) || (vlan_r && (len_nxt > mtupri_r[pcp_r]));
   wire bad = ver_r && (state_r == S_PASS) && (in_data != icv_r);
   wire late_drop = over || bad;
   wire acc_ing = ver_r && (state_r == S_PASS) && !in_eop;
   wire [2:0] hidx = in_sop ? 3'h0 : hcnt_r;

   // frame state machine, output register and counter updater
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_HEAD;
         for (j = 0; j < `HDR_WORDS; j = j + 1) begin
            hb_r[j] <= 32'h00000000;
         end
         hcnt_r <= 3'h0;
         ei_r <= 3'h0;
         eop_seen_r <= 1'b0;
         act_r <= `ACT_DROP;
         enc_r <= 1'b0;
         ver_r <= 1'b0;
         vlan_r <= 1'b0;
         pcp_r <= 3'h0;
         cls_r <= 3'h0;
         len_r <= 16'h0000;
         wcnt_r <= 16'h0000;
         icv_r <= 32'h00000000;
         pn_r <= `PN_INIT;
         pend_r <= 8'h00;
         rmw_r <= 1'b0;
         uidx_r <= 3'h0;
         clr_r <= 4'h0;
         out_valid_r <= 1'b0;
         out_data_r <= 32'h00000000;
         out_sop_r <= 1'b0;
         out_eop_r <= 1'b0;
         out_drop_r <= 1'b0;
      end else begin
         if (can) begin
            out_valid_r <= prod;
            out_data_r <= pdata;
            out_sop_r <= psop;
            out_eop_r <= peop;
            out_drop_r <= peop && late_drop;
         end
         if (fire) begin
            len_r <= len_nxt;
         end
         if (fire && penc) begin
            wcnt_r <= wcnt_r + 16'h0001;
            icv_r <= {icv_r[30:0], icv_r[31]} ^ pdata ^ key_r;
         end else if (fire && acc_ing) begin
            icv_r <= {icv_r[30:0], icv_r[31]} ^ in_data ^ key_r;
         end
         if (fire && peop) begin
            pend_r <= fin_mask(over, bad, enc_r, ver_r, act_r == `ACT_BYPASS) & ~skip_r;
         end
         case (state_r)
            S_HEAD: begin
               if (accept) begin
                  hb_r[hidx] <= in_data;
                  hcnt_r <= hidx + 3'h1;
                  if (in_eop || hidx == `LAST_PLAIN) begin
                     eop_seen_r <= in_eop;
                     state_r <= S_DEC;
                  end
               end
            end
            S_DEC: begin
               if (stat_free) begin
                  cls_r <= cls;
                  hcnt_r <= 3'h0;
                  if (early_drop) begin
                     pend_r <= (runt || viol ? (8'h01 << `ST_DCOMP) :
                               chk_drop ? (8'h01 << `ST_DCHK) : (8'h01 << `ST_DCLASS)) & ~skip_r;
                     state_r <= eop_seen_r ? S_HEAD : S_DISC;
                  end else begin
                     act_r <= dec_act;
                     enc_r <= egress && (dec_act == `ACT_MACSEC);
                     ver_r <= !egress && (dec_act == `ACT_MACSEC);
                     vlan_r <= vlan;
                     pcp_r <= hb_r[3][15:13];
                     ei_r <= 3'h0;
                     len_r <= 16'h0000;
                     wcnt_r <= 16'h0000;
                     icv_r <= 32'h00000000;
                     state_r <= S_EMIT;
                  end
               end
            end
            S_EMIT: begin
               if (fire) begin
                  ei_r <= ei_r + 3'h1;
                  if (ei_r == last_ei) begin
                     state_r <= !eop_seen_r ? S_PASS : (enc_r ? S_ICV : S_HEAD);
                  end
               end
            end
            S_PASS: begin
               if (fire && in_eop) begin
                  state_r <= enc_r ? S_ICV : S_HEAD;
               end
            end
            S_ICV: begin
               if (fire) begin
                  pn_r <= pn_r + 32'h00000001;
                  state_r <= S_HEAD;
               end
            end
            S_DISC: begin
               if (accept && in_eop) begin
                  state_r <= S_HEAD;
               end
            end
            default: begin
               state_r <= S_HEAD;
            end
         endcase
         // zero sweep after reset, then read-modify-write per pending bit
         if (!clr_done) begin
            clr_r <= clr_r + 4'h1;
         end else if (rmw_r) begin
            pend_r[uidx_r] <= 1'b0;
            rmw_r <= 1'b0;
         end else if (ustart) begin
            uidx_r <= low_bit(pend_r);
            rmw_r <= 1'b1;
         end
      end
   end

   // ram port: sweep, then updater write, then bus, then updater read
   wire ram_we = !clr_done || rmw_r || (grant && pwrite);
   wire [2:0] ram_addr = !clr_done ? clr_r[2:0] : rmw_r ? uidx_r :
                         grant ? paddr[4:2] : low_bit(pend_r);
   wire [31:0] ram_wd = !clr_done ? 32'h00000000 : rmw_r ? (ram_rd + 32'h00000001) : pwdata;
   stat_ram u_stat (.pclk(pclk), .addr(ram_addr), .we(ram_we), .wdata(ram_wd),
      .rdata(ram_rd));

   // apb decode
   wire in_mp = (paddr >= `A_MTUPRI) && (paddr < `A_MTUPRI_E);
   wire in_cr = (paddr >= `A_CRULE) && (paddr < `A_CRULE_E);
   wire in_fl = (paddr >= `A_FLOW) && (paddr < `A_FLOW_E);
   wire in_ck = (paddr >= `A_CHK) && (paddr < `A_CHK_E);
   wire in_st = (paddr >= `A_STAT) && (paddr < `A_STAT_E);
   wire [11:0] off_c = paddr - `A_CRULE;
   wire [11:0] off_f = paddr - `A_FLOW;
   wire [11:0] off_k = paddr - `A_CHK;
   wire plain = (paddr == `A_CTRL) || (paddr == `A_DEFACT) || (paddr == `A_MTU) ||
                (paddr == `A_SKIP) || (paddr == `A_KEY) || (paddr == `A_STATUS);
   wire mapped = plain || in_mp || in_cr || in_fl || in_ck || in_st;
   assign pready = in_st ? ap_wait_r : 1'b1;
   assign pslverr = acc && !mapped;
   assign prdata = ap_wait_r ? ram_rd : rd_r;
   wire wr = acc && pwrite && pready && mapped && !in_st;

   reg [31:0] rmux;
   always @* begin
      rmux = 32'h00000000;
      if (paddr == `A_CTRL) rmux = {30'h0, ctrl_r};
      else if (paddr == `A_DEFACT) rmux = {24'h0, defact_r};
      else if (paddr == `A_MTU) rmux = {16'h0, mtu_r};
      else if (paddr == `A_SKIP) rmux = {24'h0, skip_r};
      else if (paddr == `A_KEY) rmux = key_r;
      else if (paddr == `A_STATUS) rmux = {pn_r[15:0], 5'h0, cls_r, 2'h0, state_r};
      else if (in_mp) rmux = {16'h0, mtupri_r[paddr[4:2]]};
      else if (in_cr) rmux = crule_r[off_c[6:2]];
      else if (in_fl) rmux = flow_r[off_f[3:2]];
      else if (in_ck) rmux = chk_r[off_k[4:2]];
   end

   // configuration registers; read data captured in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `CTRL_RST;
         defact_r <= `DEFACT_RST;
         mtu_r <= `MTU_RST;
         skip_r <= 8'h00;
         key_r <= 32'h00000000;
         rd_r <= 32'h00000000;
         ap_wait_r <= 1'b0;
         for (q = 0; q < `N_CHK; q = q + 1) begin
            mtupri_r[q] <= `MTU_RST;
            chk_r[q] <= 32'h00000000;
         end
         for (q = 0; q < `N_CRULE; q = q + 1) begin
            crule_r[q] <= 32'h00000000;
         end
         for (q = 0; q < `N_FLOW; q = q + 1) begin
            flow_r[q] <= 32'h00000000;
         end
      end else begin
         ap_wait_r <= grant;
         if (psel && !penable) begin
            rd_r <= rmux;
         end
         if (wr) begin
            if (paddr == `A_CTRL) ctrl_r <= pwdata[1:0];
            if (paddr == `A_DEFACT) defact_r <= pwdata[7:0];
            if (paddr == `A_MTU) mtu_r <= pwdata[15:0];
            if (paddr == `A_SKIP) skip_r <= pwdata[7:0];
            if (paddr == `A_KEY) key_r <= pwdata;
            if (in_mp) mtupri_r[paddr[4:2]] <= pwdata[15:0];
            if (in_cr) crule_r[off_c[6:2]] <= pwdata;
            if (in_fl) flow_r[off_f[3:2]] <= pwdata;
            if (in_ck) chk_r[off_k[4:2]] <= pwdata;
         end
      end
   end

   assign out_valid = out_valid_r;
   assign out_data = out_data_r;
   assign out_sop = out_sop_r;
   assign out_eop = out_eop_r;
   assign out_drop = out_drop_r;
endmodule
`default_nettype wire

// >>> logic/macsec_map.vh
`ifndef MACSEC_MAP_VH
`define MACSEC_MAP_VH
// register byte addresses and region ends
`define A_CTRL      12'h000
`define A_DEFACT    12'h004
`define A_MTU       12'h008
`define A_SKIP      12'h00c
`define A_KEY       12'h010
`define A_STATUS    12'h014
`define A_MTUPRI    12'h020
`define A_MTUPRI_E  12'h040
`define A_CRULE     12'h040
`define A_CRULE_E   12'h094
`define A_FLOW      12'h100
`define A_FLOW_E    12'h110
`define A_CHK       12'h140
`define A_CHK_E     12'h160
`define A_STAT      12'h200
`define A_STAT_E    12'h220
// table sizes
`define N_CRULE     21
`define N_FLOW      4
`define N_CHK       8
`define HDR_WORDS   3'h5
`define LAST_PLAIN  3'h4
`define LAST_ENC    3'h6
// control bits
`define C_EN        0
`define C_EGR       1
// rule word fields
`define RF_ET       15:0
`define RF_EN       16
`define RF_USEF     17
`define RF_FLAGS    19:18
`define RF_ACT      21:20
`define RF_PRIO     24:22
// actions
`define ACT_DROP    2'h0
`define ACT_BYPASS  2'h1
`define ACT_MACSEC  2'h2
// frame constants
`define ET_VLAN     16'h8100
`define ET_SECTAG   16'h88e5
`define TCI_VER     7
`define TCI_EGR     8'h0c
`define WORD_BYTES  16'h0004
// statistics counter indices
`define ST_PASS     0
`define ST_DCLASS   1
`define ST_DCHK     2
`define ST_DCOMP    3
`define ST_DMTU     4
`define ST_PROT     5
`define ST_VALID    6
`define ST_BYP      7
// reset values
`define CTRL_RST    2'h1
`define DEFACT_RST  8'hff
`define MTU_RST     16'h0600
`define PN_INIT     32'h00000001
`endif

// >>> logic/stat_ram.v
`timescale 1ns/100ps
`default_nettype none
module stat_ram (
   input wire pclk, // clock
   input wire [2:0] addr, // counter index
   input wire we, // write strobe
   input wire [31:0] wdata, // write data
   output reg [31:0] rdata // registered read data
);
   reg [31:0] mem [0:7];
   // single port, read data one cycle after address
   always @(posedge pclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

// >>> tb/mac_sink.sv
`timescale 1ns/100ps
`default_nettype none
module mac_sink (
   input wire pclk, // clock
   input wire presetn, // reset, active low
   input wire slow, // stall every other cycle
   input wire out_valid, // word valid
   input wire [31:0] out_data, // word
   input wire out_eop, // last word
   input wire out_drop, // discard frame
   output logic out_ready // accept word
);
   logic [31:0] cur[$];
   logic [31:0] got[$];
   logic tick_r;
   // stall pattern, slow mode exercises the output hold
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tick_r <= 1'b0;
      else
         tick_r <= !tick_r;
   end
   assign out_ready = !slow || tick_r;
   // a frame flagged at its last word is thrown away whole
   always @(posedge pclk) begin
      if (presetn && out_valid && out_ready) begin
         cur.push_back(out_data);
         if (out_eop) begin
            if (!out_drop) foreach (cur[i]) got.push_back(cur[i]);
            cur.delete();
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/macsec_frame_pipeline_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "macsec_map.vh"
module macsec_frame_pipeline_monitor (
   input wire pclk, // clock
   input wire presetn, // reset, active low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire [11:0] paddr, // apb address
   input wire pready, // apb ready
   input wire pslverr, // apb error
   input wire out_valid, // mac word valid
   input wire out_ready, // mac ready
   input wire [31:0] out_data, // mac data
   input wire out_sop, // first word
   input wire out_eop, // last word
   input wire out_drop // discard flag
);
   reg open_r;
   // frame under way on the mac side, so body words can be placed
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         open_r <= 1'b0;
      else if (out_valid && out_ready)
         open_r <= !out_eop;
   end
   sequence s_stat_acc;
      psel && penable && paddr >= `A_STAT && paddr < `A_STAT_E;
   endsequence
   property p_stat_wait;
      @(posedge pclk) disable iff (!presetn) s_stat_acc |-> ##[0:4] pready;
   endproperty
   a_stat_wait: assert property (p_stat_wait) else $error("stat access never answered");
   property p_stat_ws;
      @(posedge pclk) disable iff (!presetn) s_stat_acc ##0 $rose(penable) |-> !pready;
   endproperty
   a_stat_ws: assert property (p_stat_ws) else $error("stat access without wait");
   property p_reg_ready;
      @(posedge pclk) disable iff (!presetn) psel && penable && paddr < `A_STAT |-> pready;
   endproperty
   a_reg_ready: assert property (p_reg_ready) else $error("register access stalled");
   property p_slverr;
      @(posedge pclk) disable iff (!presetn) pslverr |-> psel && penable && pready;
   endproperty
   a_slverr: assert property (p_slverr) else $error("error outside access phase");
   property p_out_hold;
      @(posedge pclk) disable iff (!presetn) out_valid && !out_ready |=>
         out_valid && $stable({out_data, out_sop, out_eop, out_drop});
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("output word changed in stall");
   property p_sop_first;
      @(posedge pclk) disable iff (!presetn) out_valid && out_sop |-> !open_r;
   endproperty
   a_sop_first: assert property (p_sop_first) else $error("start inside a frame");
   property p_body_inside;
      @(posedge pclk) disable iff (!presetn) out_valid && !out_sop |-> open_r;
   endproperty
   a_body_inside: assert property (p_body_inside) else $error("word outside a frame");
   property p_reset_quiet;
      @(posedge pclk) !presetn |-> !out_valid && !pslverr;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
endmodule
bind macsec_frame_pipeline macsec_frame_pipeline_monitor u_mon (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
   .out_sop(out_sop), .out_eop(out_eop), .out_drop(out_drop));
`default_nettype wire

// >>> tb/macsec_frame_pipeline_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "macsec_map.vh"
module macsec_frame_pipeline_test;
   logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic in_valid = 1'b0, in_sop = 1'b0, in_eop = 1'b0, slow = 1'b1, serr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, in_data = 32'h0, rq, p0;
   wire [31:0] prdata, out_data;
   wire pready, pslverr, in_ready, out_valid, out_ready, out_sop, out_eop, out_drop;
   int fail_count = 0, cmp_count = 0;
   macsec_frame_pipeline u_macsec_frame_pipeline (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
      .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
      .out_sop(out_sop), .out_eop(out_eop), .out_drop(out_drop));
   mac_sink u_mac_sink (.pclk(pclk), .presetn(presetn), .slow(slow), .out_valid(out_valid),
      .out_data(out_data), .out_eop(out_eop), .out_drop(out_drop), .out_ready(out_ready));
   always #50 pclk = ~pclk;
   function automatic logic [31:0] fw(input logic [15:0] et, input int k);
      fw = (k == 3) ? {et, 16'h0000} : (32'h5a5a0000 | 32'(k));
   endfunction
   function automatic logic [11:0] sa(input int i);
      sa = `A_STAT + 12'(4 * i);
   endfunction
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", s, e, g);
         fail_count++;
      end
   endtask
   // one apb transfer; request held until pready is seen at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fail_count++;
      rq = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input string s);
      apb(1'b0, a, 32'h0);
      chk(s, e, rq);
   endtask
   // frame on the switch side, words back to back when ready
   task send(input logic [15:0] et, input int n);
      int k, t;
      for (k = 0; k < n; k++) begin
         @(posedge pclk);
         in_valid <= 1'b1;
         in_data <= fw(et, k);
         in_sop <= (k == 0);
         in_eop <= (k == n - 1);
         t = 0;
         do begin
            @(negedge pclk);
            t++;
         end while (in_ready !== 1'b1 && t < 200);
         if (t >= 200) fail_count++;
      end
      @(posedge pclk);
      in_valid <= 1'b0;
   endtask
   // drain: output quiet for a while, bounded
   task settle;
      int idle, t;
      idle = 0;
      for (t = 0; t < 400 && idle < 15; t++) begin
         @(negedge pclk);
         idle = (out_valid === 1'b1) ? 0 : idle + 1;
      end
   endtask
   // passed frames must all be et/n copies, in order
   task pass_chk(input logic [15:0] et, input int n, input int f, input string s);
      settle;
      chk("frame words", 32'(n * f), 32'(u_mac_sink.got.size()));
      foreach (u_mac_sink.got[i]) chk("frame word", fw(et, i % n), u_mac_sink.got[i]);
      u_mac_sink.got.delete();
      $display("test %s done", s);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      test_done;
   end
   initial begin
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`A_CTRL, {30'h0, `CTRL_RST}, "ctrl");
      rd(`A_DEFACT, {24'h0, `DEFACT_RST}, "defact");
      rd(`A_MTU, {16'h0, `MTU_RST}, "mtu");
      apb(1'b0, 12'h0f0, 32'h0);
      chk("slverr", 32'h1, 32'(serr));
      send(16'h0800, 6);
      pass_chk(16'h0800, 6, 1, "ingress");
      rd(sa(`ST_DCLASS), 32'h0, "swept");
      wr(`A_DEFACT, 32'h000000fe);
      wr(`A_FLOW, 32'h00110800);
      send(16'h0800, 5);
      send(16'h0801, 5);
      send(16'h0800, 5);
      pass_chk(16'h0800, 5, 2, "order");
      rd(sa(`ST_DCLASS), 32'h1, "class drops");
      wr(`A_FLOW + 12'h004, 32'h00410800);
      send(16'h0800, 5);
      pass_chk(16'h0800, 5, 0, "priority");
      wr(`A_FLOW, 32'h0);
      wr(`A_FLOW + 12'h004, 32'h0);
      wr(`A_DEFACT, 32'h000000ef);
      wr(`A_CRULE + 12'h050, 32'h000188cc);
      send(16'h88cc, 5);
      send(16'h0800, 5);
      pass_chk(16'h0800, 5, 1, "control");
      wr(`A_MTU, 32'h00000014);
      send(16'h0800, 6);
      send(16'h0800, 5);
      pass_chk(16'h0800, 5, 1, "mtu");
      rd(sa(`ST_DMTU), 32'h1, "mtu drops");
      wr(`A_MTU, {16'h0, `MTU_RST});
      wr(`A_DEFACT, 32'h000000ff);
      wr(`A_SKIP, 32'h00000001);
      apb(1'b0, sa(`ST_PASS), 32'h0);
      p0 = rq;
      wr(`A_FLOW, 32'h00210800);
      wr(`A_CTRL, 32'h00000003);
      send(16'h0800, 6);
      settle;
      chk("egress words", 32'h9, 32'(u_mac_sink.got.size()));
      chk("egress w0", fw(16'h0800, 0), u_mac_sink.got[0]);
      chk("egress w2", fw(16'h0800, 2), u_mac_sink.got[2]);
      chk("sectag", {`ET_SECTAG, `TCI_EGR, 8'h00}, u_mac_sink.got[3]);
      chk("pn", `PN_INIT, u_mac_sink.got[4]);
      rd(sa(`ST_PROT), 32'h1, "protected");
      rd(sa(`ST_PASS), p0, "skipped");
      u_mac_sink.got.delete();
      $display("test egress done");
      wr(`A_CTRL, 32'h00000001);
      wr(`A_FLOW, 32'h002188e5);
      send(`ET_SECTAG, 6);
      pass_chk(`ET_SECTAG, 6, 0, "icv check");
      rd(sa(`ST_DCOMP), 32'h1, "icv drops");
      test_done;
   end
endmodule
`default_nettype wire
